// [hw/prio_priority_interrupt_unit_regs.vh]
`ifndef PRIO_PRIORITY_INTERRUPT_UNIT_REGS_VH
`define PRIO_PRIORITY_INTERRUPT_UNIT_REGS_VH

// Register addresses, used as printed on the register port
`define PRIO_REG_A_ADDR        32'hffff8348
`define PRIO_REG_B_ADDR        32'hffff834a
`define PRIO_REG_C_ADDR        32'hffff834c
`define PRIO_REG_D_ADDR        32'hffff834e
`define PRIO_REG_E_ADDR        32'hffff8350
`define PRIO_REG_F_ADDR        32'hffff8352
`define PRIO_REG_G_ADDR        32'hffff8354
`define PRIO_REG_H_ADDR        32'hffff8356
`define INT_CONTROL_ADDR       32'hffff8358
`define PIN_STATUS_ADDR        32'hffff835a

// Register indices inside the block
`define IDX_PRIO_A             4'h0
`define IDX_CONTROL            4'h8
`define IDX_STATUS             4'h9
`define IDX_NONE               4'hf

// Reset values
`define PRIO_RESET             16'h0000
`define STATUS_RESET           16'h0000
`define CONTROL_RESET_NMI_HI   16'h8000
`define CONTROL_RESET_NMI_LO   16'h0000

// Control register fields
`define CTRL_NMI_LEVEL_BIT     15
`define CTRL_NMI_EDGE_BIT      8
`define CTRL_SENSE_MSB         7

// Priority levels
`define LEVEL_NMI              5'h10
`define LEVEL_BREAK            5'h0f
`define MASK_NMI               4'hf
`define MASK_BREAK             4'hf

// Vector numbers
`define VEC_NMI                8'h0b
`define VEC_BREAK              8'h0c
`define VEC_PIN_BASE           8'h40
`define VEC_PERIPH_BASE        8'h48
`define VEC_PERIPH_STRIDE      8'h04

// Source codes of the presented request
`define SRC_NMI                7'h00
`define SRC_BREAK              7'h01
`define SRC_PIN_BASE           7'h02
`define SRC_PERIPH_BASE        7'h0a

`endif

// [hw/priority_interrupt_unit.v]
`timescale 1ns/1ns
`include "prio_priority_interrupt_unit_regs.vh"

// Contract
// - Levels 0 to 16; level 0 masks
// - Nonmaskable level 16, always accepted
// - Nonmaskable edge, polarity set by control bit
// - Nonmaskable acceptance sets mask to 15
// - Break edge, level 15, pending, mask 15
// - Per-pin low-level or falling-edge select
// - Pin priorities in first two registers
// - Level mode follows pin; flag shows it
// - Edge mode latches until accepted
// - Edge status flags cleared by zero writes or by acceptance
// - Pin acceptance loads mask with pin priority
// - Peripheral groups in registers C to H
// - Peripheral acceptance loads mask with priority
// - Distinct vector number per source
// - Fixed order inside a shared field
// - Reset puts all priorities at zero
// - Equal priorities resolved by default order
// - Control reset value follows nonmaskable pin
module priority_interrupt_unit #(
   parameter GROUPS = 24,
   parameter SUBS   = 4
) (
   input  wire                   mclk,
   input  wire                   arst_n,
   input  wire [31:0]            reg_addr,
   input  wire [15:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [15:0]            reg_rdata,
   input  wire                   nmi_pin,
   input  wire [7:0]             external_request_pins_n,
   input  wire                   break_request,
   input  wire [GROUPS*SUBS-1:0] periph_req,
   input  wire [3:0]             cpu_mask_level,
   output reg                    cpu_irq_req,
   output reg  [4:0]             cpu_irq_level,
   output reg  [7:0]             cpu_irq_vector,
   input  wire                   cpu_irq_ack,
   output reg                    cpu_mask_load,
   output reg  [3:0]             cpu_mask_value
);

   reg  [15:0]       prio_q [0:7];
   reg               nmi_edge_sel_q;
   reg  [7:0]        pin_sense_select_q;
   reg  [7:0]        edge_flag_q;
   reg  [1:0]        nmi_sync_q;
   reg               nmi_prev_q;
   reg               nmi_pend_q;
   reg  [7:0]        pin_sync1_q;
   reg  [7:0]        pin_sync2_q;
   reg  [7:0]        pin_prev_q;
   reg               brk_prev_q;
   reg               brk_pend_q;
   reg  [6:0]        src_q;
   reg               ctrl_init_q;

   wire [3:0]        idx_w;
   wire [127:0]      prio_flat;
   wire [7:0]        pin_low;
   wire [7:0]        pin_fall;
   wire [7:0]        pin_request_flag;
   wire              nmi_edge;
   wire              accept;
   wire [15:0]       control_rd;

   // Register address decode, used for both read and write
   function [3:0] reg_index;
      input [31:0] a;
      begin
         case (a)
            `PRIO_REG_A_ADDR: reg_index = 4'h0;
            `PRIO_REG_B_ADDR: reg_index = 4'h1;
            `PRIO_REG_C_ADDR: reg_index = 4'h2;
            `PRIO_REG_D_ADDR: reg_index = 4'h3;
            `PRIO_REG_E_ADDR: reg_index = 4'h4;
            `PRIO_REG_F_ADDR: reg_index = 4'h5;
            `PRIO_REG_G_ADDR: reg_index = 4'h6;
            `PRIO_REG_H_ADDR: reg_index = 4'h7;
            `INT_CONTROL_ADDR: reg_index = `IDX_CONTROL;
            `PIN_STATUS_ADDR: reg_index = `IDX_STATUS;
            default: reg_index = `IDX_NONE;
         endcase
      end
   endfunction

   // Four-bit field n: register n/4, first field in bits 15-12
   function [3:0] field_of;
      input [127:0] flat;
      input [4:0]   n;
      reg   [6:0]   base;
      begin
         base = {n, 2'b00};
         field_of = flat[7'd127 - base -: 4];
      end
   endfunction

   assign idx_w = reg_index(reg_addr);

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flat
         assign prio_flat[127-16*gi -: 16] = prio_q[gi];
      end
   endgenerate

   assign pin_low  = ~pin_sync2_q;
   assign pin_fall = pin_prev_q & ~pin_sync2_q;

   assign pin_request_flag = (pin_sense_select_q & edge_flag_q) |
                             (~pin_sense_select_q & pin_low);

   assign nmi_edge = nmi_edge_sel_q ? (~nmi_prev_q & nmi_sync_q[1])
                                    : (nmi_prev_q & ~nmi_sync_q[1]);

   assign accept = cpu_irq_ack & cpu_irq_req;

   // level bit reads the nonmaskable pin after its two-stage synchroniser
   assign control_rd = {nmi_sync_q[1], 6'h00, nmi_edge_sel_q,
                        pin_sense_select_q};

   // Pin synchronisers; second stage feeds everything except the break edge, which uses break_request raw
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_sync_q  <= 2'b00;
         nmi_prev_q  <= 1'b0;
         pin_sync1_q <= 8'hff;
         pin_sync2_q <= 8'hff;
         pin_prev_q  <= 8'hff;
         brk_prev_q  <= 1'b0;
      end else begin
         nmi_sync_q  <= {nmi_sync_q[0], nmi_pin};
         nmi_prev_q  <= nmi_sync_q[1];
         pin_sync1_q <= external_request_pins_n;
         pin_sync2_q <= pin_sync1_q;
         pin_prev_q  <= pin_sync2_q;
         brk_prev_q  <= break_request;
      end
   end

   // Register writes
   integer k;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < 8; k = k + 1) begin
            prio_q[k] <= `PRIO_RESET;
         end
         nmi_edge_sel_q     <= 1'b0;
         pin_sense_select_q <= 8'h00;
         ctrl_init_q        <= 1'b0;
      end else begin
         if (reg_wr && idx_w < 4'h8) begin
            prio_q[idx_w[2:0]] <= reg_wdata;
         end
         if (reg_wr && idx_w == `IDX_CONTROL) begin
            nmi_edge_sel_q     <= reg_wdata[`CTRL_NMI_EDGE_BIT];
            pin_sense_select_q <= reg_wdata[`CTRL_SENSE_MSB:0];
         end
         ctrl_init_q <= 1'b1;
      end
   end

   integer fk;
   // Edge-mode flags and pending events; a set beats a clear
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         edge_flag_q <= 8'h00;
         nmi_pend_q  <= 1'b0;
         brk_pend_q  <= 1'b0;
      end else begin
         for (fk = 0; fk < 8; fk = fk + 1) begin
            if (reg_wr && idx_w == `IDX_STATUS && !reg_wdata[fk]) begin
               edge_flag_q[fk] <= 1'b0;
            end
            if (accept && src_q == `SRC_PIN_BASE + fk[6:0]) begin
               edge_flag_q[fk] <= 1'b0;
            end
            if (pin_sense_select_q[fk] && pin_fall[fk]) begin
               edge_flag_q[fk] <= 1'b1;
            end
         end
         if (accept && src_q == `SRC_NMI) begin
            nmi_pend_q <= 1'b0;
         end
         if (ctrl_init_q && nmi_edge) begin
            nmi_pend_q <= 1'b1;
         end
         if (accept && src_q == `SRC_BREAK) begin
            brk_pend_q <= 1'b0;
         end
         if (break_request && !brk_prev_q) begin
            brk_pend_q <= 1'b1;
         end
      end
   end

   // Arbitration over all sources in default order
   reg        best_v;
   reg [4:0]  best_l;
   reg [7:0]  best_vec;
   reg [6:0]  best_s;
   reg [4:0]  lvl;
   integer    pk;
   integer    g;
   integer    s;
   always @* begin
      best_v   = 1'b0;
      best_l   = 5'h00;
      best_vec = 8'h00;
      best_s   = 7'h00;
      lvl      = 5'h00;
      if (nmi_pend_q) begin
         best_v   = 1'b1;
         best_l   = `LEVEL_NMI;
         best_vec = `VEC_NMI;
         best_s   = `SRC_NMI;
      end
      if (brk_pend_q && `LEVEL_BREAK > {1'b0, cpu_mask_level} &&
          (!best_v || `LEVEL_BREAK > best_l)) begin
         best_v   = 1'b1;
         best_l   = `LEVEL_BREAK;
         best_vec = `VEC_BREAK;
         best_s   = `SRC_BREAK;
      end
      for (pk = 0; pk < 8; pk = pk + 1) begin
         lvl = {1'b0, field_of(prio_flat, pk[4:0])};
         if (pin_request_flag[pk] && lvl > {1'b0, cpu_mask_level} &&
             (!best_v || lvl > best_l)) begin
            best_v   = 1'b1;
            best_l   = lvl;
            best_vec = `VEC_PIN_BASE + pk[7:0];
            best_s   = `SRC_PIN_BASE + pk[6:0];
         end
      end
      for (g = 0; g < GROUPS; g = g + 1) begin
         lvl = {1'b0, field_of(prio_flat, g[4:0] + 5'd8)};
         // lower sub index wins inside group
         for (s = 0; s < SUBS; s = s + 1) begin
            if (periph_req[g*SUBS+s] && lvl > {1'b0, cpu_mask_level} &&
                (!best_v || lvl > best_l)) begin
               best_v   = 1'b1;
               best_l   = lvl;
               best_vec = `VEC_PERIPH_BASE +
                          `VEC_PERIPH_STRIDE * g[7:0] + s[7:0];
               best_s   = `SRC_PERIPH_BASE + g[6:0] * SUBS[6:0] + s[6:0];
            end
         end
      end
   end

   // Presented request and mask update
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_irq_req    <= 1'b0;
         cpu_irq_level  <= 5'h00;
         cpu_irq_vector <= 8'h00;
         src_q          <= 7'h00;
         cpu_mask_load  <= 1'b0;
         cpu_mask_value <= 4'h0;
      end else begin
         // Drop for a cycle after acceptance so a stale source is not
         // presented twice while its pending bit clears
         cpu_irq_req    <= best_v & ~accept;
         cpu_irq_level  <= best_l;
         cpu_irq_vector <= best_vec;
         src_q          <= best_s;
         cpu_mask_load  <= accept;
         if (accept) begin
            if (src_q == `SRC_NMI) begin
               cpu_mask_value <= `MASK_NMI;
            end else if (src_q == `SRC_BREAK) begin
               cpu_mask_value <= `MASK_BREAK;
            end else begin
               cpu_mask_value <= cpu_irq_level[3:0];
            end
         end
      end
   end

   // Read data, one cycle after the strobe
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (idx_w)
            `IDX_CONTROL: reg_rdata <= control_rd;
            `IDX_STATUS:  reg_rdata <= {8'h00, pin_request_flag};
            `IDX_NONE:    reg_rdata <= 16'h0000;
            default:      reg_rdata <= prio_q[idx_w[2:0]];
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule

// [bench/cpu_core_model.sv]
`timescale 1ns/1ns
// Processor side: takes the presented request, loads the mask, and
// returns it to 0 a few cycles later as a handler exit would
module cpu_core_model (
   input  wire       mclk,
   input  wire       arst_n,
   input  wire       cpu_irq_req,
   input  wire       cpu_mask_load,
   input  wire [3:0] cpu_mask_value,
   input  wire       slow,
   output reg        cpu_irq_ack,
   output reg  [3:0] cpu_mask_level
);
   reg [2:0] wait_q;
   reg [2:0] hold_q;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_irq_ack <= 1'b0;
         cpu_mask_level <= 4'h0;
         wait_q <= 3'h0;
         hold_q <= 3'h0;
      end else begin
         cpu_irq_ack <= 1'b0;
         if (cpu_mask_load) begin
            cpu_mask_level <= cpu_mask_value;
            hold_q <= 3'h4;
         end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
            if (hold_q == 3'h1)
               cpu_mask_level <= 4'h0;
         end
         // Slow mode stalls three cycles before taking a request
         if (cpu_irq_req && !cpu_irq_ack) begin
            if (slow && wait_q != 3'h3) begin
               wait_q <= wait_q + 3'h1;
            end else begin
               cpu_irq_ack <= 1'b1;
               wait_q <= 3'h0;
            end
         end
      end
   end
endmodule

// [bench/priority_interrupt_unit_properties.sv]
`timescale 1ns/1ns
module irq_checker (
   input wire       mclk,
   input wire       arst_n,
   input wire [3:0] cpu_mask_level,
   input wire       cpu_irq_req,
   input wire [4:0] cpu_irq_level,
   input wire [7:0] cpu_irq_vector,
   input wire       cpu_irq_ack,
   input wire       cpu_mask_load,
   input wire [3:0] cpu_mask_value
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   wire take = cpu_irq_ack && cpu_irq_req;
   AST_MASK_LOAD: assert property (take |=> cpu_mask_load)
      else $error("no mask load after ack");
   AST_LOAD_CAUSE: assert property (cpu_mask_load |-> $past(take))
      else $error("mask load without ack");
   AST_REQ_DROP: assert property (take |=> !cpu_irq_req)
      else $error("request stays after ack");
   AST_NMI_VEC: assert property (cpu_irq_req && cpu_irq_level == 5'h10
      |-> cpu_irq_vector == 8'h0b) else $error("bad nonmaskable vector");
   AST_BREAK: assert property (cpu_irq_req && cpu_irq_vector == 8'h0c
      |-> cpu_irq_level == 5'h0f) else $error("bad break level");
   AST_NMI_MASK: assert property (take && cpu_irq_level == 5'h10
      |=> cpu_mask_value == 4'hf) else $error("bad nonmaskable mask");
   AST_PRIO_MASK: assert property (take && !cpu_irq_level[4]
      |=> {1'b0, cpu_mask_value} == $past(cpu_irq_level))
      else $error("mask differs from level");
   AST_ABOVE_MASK: assert property (cpu_irq_req && !cpu_irq_level[4]
      |-> cpu_irq_level > {1'b0, $past(cpu_mask_level)})
      else $error("request not above mask");
   AST_LEVEL_NZ: assert property (cpu_irq_req |-> cpu_irq_level != 5'h00)
      else $error("level zero presented");
endmodule
bind priority_interrupt_unit irq_checker chk_u (.mclk, .arst_n,
   .cpu_mask_level, .cpu_irq_req, .cpu_irq_level, .cpu_irq_vector,
   .cpu_irq_ack, .cpu_mask_load, .cpu_mask_value);

// [bench/priority_interrupt_unit_bench.sv]
`timescale 1ns/1ns
`include "prio_priority_interrupt_unit_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module priority_interrupt_unit_bench;
   reg         mclk;
   reg         arst_n;
   reg         reg_wr;
   reg         reg_rd;
   reg         nmi_pin;
   reg         break_request;
   reg         slow;
   reg  [31:0] reg_addr;
   reg  [15:0] reg_wdata;
   reg  [7:0]  pins_n;
   reg  [95:0] periph_req;
   wire [15:0] reg_rdata;
   wire [3:0]  cpu_mask_level;
   wire [3:0]  cpu_mask_value;
   wire        cpu_irq_req;
   wire        cpu_irq_ack;
   wire        cpu_mask_load;
   wire [4:0]  cpu_irq_level;
   wire [7:0]  cpu_irq_vector;
   integer     failures = 0;
   integer     checked = 0;
   integer     cycles = 0;
   priority_interrupt_unit dut_u (.mclk(mclk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin(nmi_pin),
      .external_request_pins_n(pins_n), .break_request(break_request),
      .periph_req(periph_req), .cpu_mask_level(cpu_mask_level),
      .cpu_irq_req(cpu_irq_req), .cpu_irq_level(cpu_irq_level),
      .cpu_irq_vector(cpu_irq_vector), .cpu_irq_ack(cpu_irq_ack),
      .cpu_mask_load(cpu_mask_load), .cpu_mask_value(cpu_mask_value));
   cpu_core_model cpu_u (.mclk(mclk), .arst_n(arst_n),
      .cpu_irq_req(cpu_irq_req), .cpu_mask_load(cpu_mask_load),
      .cpu_mask_value(cpu_mask_value), .slow(slow),
      .cpu_irq_ack(cpu_irq_ack), .cpu_mask_level(cpu_mask_level));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task end_sim;
      begin
         if (failures == 0 && checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // Whole run is well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         end_sim;
      end
   end
   task wr(input [31:0] a, input [15:0] d);
      begin
         @(posedge mclk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge mclk);
         reg_wr <= 1'b0;
      end
   endtask
   task rdc(input [31:0] a, input [15:0] e);
      begin
         @(posedge mclk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1 `CHK(reg_rdata, e)
      end
   endtask
   task irq(input [4:0] l, input [7:0] v, input [3:0] m);
      integer i;
      begin
         #1;
         i = 0;
         while (cpu_irq_req !== 1'b1 && i < 50) begin
            @(posedge mclk);
            #1 i++;
         end
         `CHK(cpu_irq_req, 1'b1)
         `CHK(cpu_irq_level, l)
         `CHK(cpu_irq_vector, v)
         i = 0;
         while (cpu_mask_load !== 1'b1 && i < 20) begin
            @(posedge mclk);
            #1 i++;
         end
         `CHK(cpu_mask_load, 1'b1)
         `CHK(cpu_mask_value, m)
         repeat (6) @(posedge mclk);
      end
   endtask
   task t_reset;
      begin
         rdc(`PRIO_REG_A_ADDR, 16'h0000);
         rdc(`PRIO_REG_H_ADDR, 16'h0000);
         rdc(`INT_CONTROL_ADDR, 16'h8000);
         rdc(`PIN_STATUS_ADDR, 16'h0000);
         wr(32'hffff835c, 16'hffff);
         rdc(32'hffff835c, 16'h0000);
      end
   endtask
   // Priorities stay 0 so the flags are never taken
   task t_flags;
      begin
         wr(`INT_CONTROL_ADDR, 16'h0001);
         pins_n <= 8'hfe;
         @(posedge mclk) pins_n <= 8'hff;
         repeat (4) @(posedge mclk);
         rdc(`PIN_STATUS_ADDR, 16'h0001);
         wr(`PIN_STATUS_ADDR, 16'hffff);
         rdc(`PIN_STATUS_ADDR, 16'h0001);
         wr(`PIN_STATUS_ADDR, 16'hfffe);
         rdc(`PIN_STATUS_ADDR, 16'h0000);
         wr(`INT_CONTROL_ADDR, 16'h0000);
         pins_n <= 8'hfb;
         repeat (4) @(posedge mclk);
         rdc(`PIN_STATUS_ADDR, 16'h0004);
         pins_n <= 8'hff;
         repeat (4) @(posedge mclk);
         rdc(`PIN_STATUS_ADDR, 16'h0000);
      end
   endtask
   task t_pins;
      begin
         wr(`INT_CONTROL_ADDR, 16'h0003);
         wr(`PRIO_REG_A_ADDR, 16'h5500);
         pins_n <= 8'hfc;
         @(posedge mclk) pins_n <= 8'hff;
         irq(5'h05, 8'h40, 4'h5);
         irq(5'h05, 8'h41, 4'h5);
      end
   endtask
   task t_nmi;
      begin
         wr(`INT_CONTROL_ADDR, 16'h0100);
         rdc(`INT_CONTROL_ADDR, 16'h8100);
         nmi_pin <= 1'b0;
         repeat (5) @(posedge mclk);
         #1 `CHK(cpu_irq_req, 1'b0)
         @(posedge mclk) nmi_pin <= 1'b1;
         irq(5'h10, 8'h0b, 4'hf);
      end
   endtask
   task t_break;
      begin
         slow <= 1'b1;
         break_request <= 1'b1;
         @(posedge mclk) break_request <= 1'b0;
         irq(5'h0f, 8'h0c, 4'hf);
         slow <= 1'b0;
      end
   endtask
   task t_periph;
      begin
         wr(`PRIO_REG_C_ADDR, 16'h3000);
         periph_req[1:0] <= 2'b11;
         irq(5'h03, 8'h48, 4'h3);
         periph_req <= 96'h0;
      end
   endtask
   // Second reset after programming; falling nonmaskable edge afterwards
   task t_rerun;
      begin
         arst_n <= 1'b0;
         repeat (3) @(posedge mclk);
         arst_n <= 1'b1;
         rdc(`PRIO_REG_A_ADDR, 16'h0000);
         rdc(`PRIO_REG_C_ADDR, 16'h0000);
         rdc(`INT_CONTROL_ADDR, 16'h8000);
         `CHK(cpu_irq_req, 1'b0)
         @(posedge mclk) nmi_pin <= 1'b0;
         irq(5'h10, 8'h0b, 4'hf);
         nmi_pin <= 1'b1;
      end
   endtask
   initial begin
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 16'h0;
      nmi_pin = 1'b1;
      break_request = 1'b0;
      slow = 1'b0;
      pins_n = 8'hff;
      periph_req = 96'h0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset;
      t_flags;
      t_pins;
      t_nmi;
      t_break;
      t_periph;
      t_rerun;
      end_sim;
   end
endmodule
